//--- hdl/hssp_pkg.sv
`default_nettype none
package hssp_pkg;
  // timing of the carrier and update events
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned PWM_HZ      = 20_000;
  localparam int unsigned PWM_US      = 50;
  localparam int unsigned PWM_CYC     = CLK_HZ / PWM_HZ;
  localparam int unsigned CNT_W       = 9;
  localparam logic [8:0]  CNT_LAST    = 9'(PWM_CYC - 1);
  localparam logic [8:0]  CNT_HALF    = 9'(PWM_CYC / 2);
  // phase accumulator and table
  localparam int unsigned IDX_W       = 16;
  localparam int unsigned TBL_N       = 256;
  localparam logic [7:0]  PH_120      = 8'h55;
  localparam int          TBL_PEAK    = 127;
  localparam int          SIN_ONE     = 1024;
  localparam int          SIN_SUM_PK  = 887;
  localparam int          HARM3_DIV   = 6;
  localparam int          MAG_FULL    = 256;
  // hall code to sector angle (upper byte of the phase index)
  localparam logic [7:0]  HALL_ANG [8] = '{8'h00, 8'h00, 8'h55, 8'h2B,
                                           8'hAB, 8'hD5, 8'h80, 8'h00};
  localparam logic [2:0]  HALL_NONE_0 = 3'h0;
  localparam logic [2:0]  HALL_NONE_1 = 3'h7;

  typedef enum logic [1:0] {
    HSSP_INIT = 2'b01,
    HSSP_RUN  = 2'b10
  } hssp_state_t;
endpackage
`default_nettype wire

//--- hdl/hssp_top.sv
`timescale 1ns/1ps
`default_nettype none
module hssp_top (
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  input  wire logic        i_enable,
  input  wire logic        i_reverse,
  input  wire logic [15:0] i_step,
  input  wire logic [7:0]  i_magnitude,
  input  wire logic [7:0]  i_dead_time,
  input  wire logic [2:0]  i_capture_state,
  input  wire logic [2:0]  i_hall,
  input  wire logic        i_fault,
  output logic      [2:0]  o_high,
  output logic      [2:0]  o_low,
  output logic             o_update,
  output logic             o_hall_event,
  output logic      [15:0] o_hall_period,
  output logic      [15:0] o_stamp,
  output logic             o_stamp_valid,
  output logic      [15:0] o_phase_index,
  output logic             o_tripped
);

  typedef struct packed {
    hssp_pkg::hssp_state_t state;
    logic [2:0]            h1;
    logic [2:0]            h2;
    logic [2:0]            h3;
    logic [2:0]            hall;
    logic                  f1;
    logic                  f2;
    logic                  f3;
    logic                  fq;
    logic                  trip;
    logic [8:0]            cnt;
    logic [15:0]           idx;
    logic [2:0][8:0]       duty;
    logic [2:0]            raw;
    logic [2:0][7:0]       dcnt;
    logic [2:0]            hi;
    logic [2:0]            lo;
    logic                  upd;
    logic                  hev;
    logic [15:0]           timer;
    logic [15:0]           last;
    logic [15:0]           period;
    logic [15:0]           stamp;
    logic                  stamp_v;
  } hssp_regs_t;

  hssp_regs_t s;
  hssp_regs_t next_s;

  // sine value scaled to SIN_ONE, parabolic-ratio approximation
  function automatic int sin_q(input int a);
    int h;
    int p;
    int v;
    h = a % (hssp_pkg::TBL_N / 2);
    p = h * (hssp_pkg::TBL_N / 2 - h);
    v = (hssp_pkg::SIN_ONE * 16 * p) / (81920 - 4 * p);
    return (a >= hssp_pkg::TBL_N / 2) ? -v : v;
  endfunction

  // fundamental plus a sixth of the third harmonic, peak near TBL_PEAK
  function automatic int tbl_entry(input int i);
    int sum;
    sum = hssp_pkg::HARM3_DIV * sin_q(i)
        + sin_q((3 * i) % hssp_pkg::TBL_N);
    return (sum * hssp_pkg::TBL_PEAK)
         / (hssp_pkg::HARM3_DIV * hssp_pkg::SIN_SUM_PK);
  endfunction

  // one electrical cycle as a constant rom, built at elaboration
  logic signed [7:0] sine_rom [hssp_pkg::TBL_N];
  for (genvar g = 0; g < hssp_pkg::TBL_N; g++)
  begin : g_rom
    assign sine_rom[g] = 8'(tbl_entry(g));
  end

  // duty = half period + signed entry scaled by magnitude
  function automatic logic [8:0] duty_of(input logic signed [7:0] e,
                                         input logic [7:0] m);
    int off;
    off = (int'(e) * int'(m) * int'(hssp_pkg::CNT_HALF))
        / (hssp_pkg::TBL_PEAK * hssp_pkg::MAG_FULL);
    return 9'(int'(hssp_pkg::CNT_HALF) + off);
  endfunction

  logic [7:0] sel_a;
  logic [7:0] sel_b;
  logic [7:0] sel_c;
  logic [7:0] hall_ang;
  logic       hall_ok;
  logic       hall_chg;
  logic       run;
  logic       off;

  // table addresses for the three phases
  always_comb
  begin
    sel_a = s.idx[15:8];
    sel_b = i_reverse ? sel_a + hssp_pkg::PH_120
                      : sel_a - hssp_pkg::PH_120;
    sel_c = i_reverse ? sel_a - hssp_pkg::PH_120
                      : sel_a + hssp_pkg::PH_120;
    hall_ang = i_reverse ? 8'(-hssp_pkg::HALL_ANG[s.h3])
                         : hssp_pkg::HALL_ANG[s.h3];
    hall_ok  = (s.h3 != hssp_pkg::HALL_NONE_0)
            && (s.h3 != hssp_pkg::HALL_NONE_1);
    hall_chg = (s.h2 == s.h3) && (s.h3 != s.hall);
    run      = (s.state == hssp_pkg::HSSP_RUN) && i_enable;
  end

  // next-state logic for the whole block
  always_comb
  begin
    next_s = s;
    // three-stage synchronisers; a change counts when stages 2 and 3 agree
    next_s.h1 = i_hall;
    next_s.h2 = s.h1;
    next_s.h3 = s.h2;
    next_s.f1 = i_fault;
    next_s.f2 = s.f1;
    next_s.f3 = s.f2;
    if (s.f2 == s.f3)
      next_s.fq = s.f3;
    next_s.upd     = 1'b0;
    next_s.hev     = 1'b0;
    next_s.stamp_v = 1'b0;
    next_s.timer   = s.timer + 16'h0001;

    // carrier counter and per-period update event
    if (s.cnt == hssp_pkg::CNT_LAST)
    begin
      next_s.cnt = '0;
      next_s.upd = 1'b1;
    end
    else
      next_s.cnt = s.cnt + 9'h001;

    // overcurrent trip holds until the period ends with the fault gone
    if (s.fq)
      next_s.trip = 1'b1;
    else if (next_s.upd)
      next_s.trip = 1'b0;

    case (s.state)
      hssp_pkg::HSSP_INIT:
      begin
        // wait for a settled, legal hall code, then start from its angle
        if (s.h2 == s.h3 && hall_ok)
        begin
          next_s.hall  = s.h3;
          next_s.idx   = {hall_ang, 8'h00};
          next_s.last  = s.timer;
          next_s.state = hssp_pkg::HSSP_RUN;
        end
      end
      hssp_pkg::HSSP_RUN:
      begin
        if (hall_chg)
        begin
          next_s.hall   = s.h3;
          next_s.hev    = 1'b1;
          next_s.period = s.timer - s.last;
          next_s.last   = s.timer;
          if (s.h3 == i_capture_state)
          begin
            next_s.stamp   = s.timer;
            next_s.stamp_v = 1'b1;
          end
          // illegal codes still count as edges but carry no angle
          if (hall_ok)
            next_s.idx = {hall_ang, 8'h00};
        end
        // step after any realign; the 16-bit sum wraps by itself
        if (next_s.upd)
          next_s.idx = next_s.idx + i_step;
      end
      default:
        next_s.state = hssp_pkg::HSSP_INIT;
    endcase

    // all three duties move in the same cycle, from one index value
    if (next_s.upd)
    begin
      next_s.duty[0] = duty_of(sine_rom[sel_a], i_magnitude);
      next_s.duty[1] = duty_of(sine_rom[sel_b], i_magnitude);
      next_s.duty[2] = duty_of(sine_rom[sel_c], i_magnitude);
    end

    // compare and dead time per pair; both sides come from one raw bit
    // so the high and low switch can never conduct together
    for (int p = 0; p < 3; p++)
    begin
      next_s.raw[p] = s.cnt < s.duty[p];
      if (next_s.raw[p] != s.raw[p])
        next_s.dcnt[p] = i_dead_time;
      else if (s.dcnt[p] != 8'h00)
        next_s.dcnt[p] = s.dcnt[p] - 8'h01;
      next_s.hi[p] = run && s.raw[p] && (s.dcnt[p] == 8'h00);
      next_s.lo[p] = run && !s.raw[p] && (s.dcnt[p] == 8'h00);
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      s       <= '0;
      s.state <= hssp_pkg::HSSP_INIT;
    end
    else
      s <= next_s;
  end

  // the raw pin gates the pairs so a trip needs no clock edge; a glitch
  // on the pin can chop a pulse, which is the safe direction to fail
  assign off           = i_fault | s.trip;
  assign o_high        = s.hi & ~{3{off}};
  assign o_low         = s.lo & ~{3{off}};
  assign o_update      = s.upd;
  assign o_hall_event  = s.hev;
  assign o_hall_period = s.period;
  assign o_stamp       = s.stamp;
  assign o_stamp_valid = s.stamp_v;
  assign o_phase_index = s.idx;
  assign o_tripped     = s.trip;

  // checks on the generated behaviour
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  a_update_slot: assert property (
    (s.cnt == hssp_pkg::CNT_LAST)
    |=> o_update && (s.cnt == 9'h000))
    else $error("update pulse not at counter wrap");
  a_update_gap: assert property (
    o_update |=> !o_update [*8])
    else $error("update pulses too close");
  a_index_step: assert property (
    (next_s.upd && !(hall_chg && hall_ok) && s.state == hssp_pkg::HSSP_RUN)
    |=> s.idx == 16'($past(s.idx) + $past(i_step)))
    else $error("phase index did not advance by step");
  a_duty_load: assert property (
    (s.duty != $past(s.duty)) |-> o_update)
    else $error("duty changed outside update");
  a_fault_off: assert property (
    i_fault |-> (o_high == 3'h0) && (o_low == 3'h0))
    else $error("outputs active during fault");
  a_trip_hold: assert property (
    (s.trip && !o_update) |-> (o_high == 3'h0) && (o_low == 3'h0))
    else $error("pulse passed while tripped");
  a_no_overlap: assert property (
    (o_high & o_low) == 3'h0)
    else $error("high and low on together");
  a_dead_gap: assert property (
    ($fell(s.hi[0]) && i_dead_time > 8'h01) |=> !s.lo[0])
    else $error("dead time not kept");
  a_hall_align: assert property (
    (s.state == hssp_pkg::HSSP_RUN && hall_chg && hall_ok && !next_s.upd)
    |=> s.idx == {$past(hall_ang), 8'h00})
    else $error("index not realigned to hall");
  a_stamp_take: assert property (
    (s.state == hssp_pkg::HSSP_RUN && hall_chg
     && s.h3 == i_capture_state)
    |=> o_stamp_valid && o_hall_event && o_stamp == $past(s.timer))
    else $error("stamp not captured");
  a_start_angle: assert property (
    (s.state == hssp_pkg::HSSP_INIT && s.h2 == s.h3 && hall_ok)
    |=> s.state == hssp_pkg::HSSP_RUN
        && s.idx == {$past(hall_ang), 8'h00})
    else $error("start angle not taken from hall");

  c_hall_edge: cover property (o_hall_event);
  c_fault_trip: cover property ($rose(o_tripped));
  c_reverse_run: cover property (i_reverse && o_update);
  c_stamp: cover property (o_stamp_valid);

endmodule // hssp_top
`default_nettype wire

//--- dv/hssp_motor.sv
`timescale 1ns/1ps
`default_nettype none
// motor behind the bridge: hall code moves one sector per request
module hssp_motor #(
  parameter int START = 3
) (
  input  wire logic       i_clock,
  input  wire logic       i_step_req,
  input  wire logic       i_dir,
  input  wire logic [2:0] i_high,
  input  wire logic [2:0] i_low,
  output logic      [2:0] o_hall,
  output var int          o_shoot
);
  // hall codes in forward rotation order
  localparam logic [2:0] CODES [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  int sector = START;
  initial o_shoot = 0;
  assign o_hall = CODES[sector];
  // a phase with both switches on would short the bus, so count it
  always @(posedge i_clock)
  begin
    if (i_step_req)
      sector <= i_dir ? (sector + 5) % 6 : (sector + 1) % 6;
    if (|(i_high & i_low))
      o_shoot <= o_shoot + 1;
  end
endmodule // hssp_motor
`default_nettype wire

//--- dv/hssp_bench.sv
`timescale 1ns/1ps
`default_nettype none
module hssp_bench;
  logic        clk = 1'b0, rst_b = 1'b0, en = 1'b0, rev = 1'b0;
  logic        fault = 1'b0, req = 1'b0, upd, hev, sv, trip;
  logic [15:0] step = 16'h0000, per, stamp, idx, last;
  logic [7:0]  mag = 8'hC0, dt = 8'h04;
  logic [2:0]  cap = 3'h0, hall, hi, lo, h4 = 3'h0;
  int          shoot, err_count = 0, cmp_count = 0, seed = 34546;
  int          n, i, k, gap, cyc = 0;
  int          hcnt [3] = '{0, 0, 0};
  int          h0 [3] = '{0, 0, 0};

  always #50 clk = ~clk;
  // running totals only; tests take snapshots, so one process owns them
  // cyc tracks the block's free timer, which counts from reset release
  always @(posedge clk)
  begin
    if (rst_b)
      cyc <= cyc + 1;
    for (int p = 0; p < 3; p++)
      hcnt[p] <= hcnt[p] + int'(hi[p]);
  end

  hssp_top dut (.i_clock(clk), .i_rst_b(rst_b), .i_enable(en),
    .i_reverse(rev), .i_step(step), .i_magnitude(mag), .i_dead_time(dt),
    .i_capture_state(cap), .i_hall(hall), .i_fault(fault), .o_high(hi),
    .o_low(lo), .o_update(upd), .o_hall_event(hev), .o_hall_period(per),
    .o_stamp(stamp), .o_stamp_valid(sv), .o_phase_index(idx),
    .o_tripped(trip));
  hssp_motor motor (.i_clock(clk), .i_step_req(req), .i_dir(rev),
    .i_high(hi), .i_low(lo), .o_hall(hall), .o_shoot(shoot));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for update (0) or hall event (1); n counts cycles
  task automatic wait_sig(input int which, input int lim);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (((which == 1) ? hev : upd) !== 1'b1 && n < lim);
    check(16'(n >= lim), 16'h0000);
  endtask

  // reverse rotation negates the sector angle
  function automatic logic [7:0] ang_of(logic [2:0] c, logic r);
    ang_of = r ? 8'(8'h00 - hssp_pkg::HALL_ANG[c]) : hssp_pkg::HALL_ANG[c];
  endfunction

  // phases whose high side switched on since snapshot b
  function automatic logic [15:0] act_since(input int b [3]);
    act_since = 16'h0000;
    for (int p = 0; p < 3; p++)
      act_since[p] = (hcnt[p] != b[p]);
  endfunction

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    en = 1'b1;
    dt = 8'($random(seed)) & 8'h1F;
    repeat (20) @(negedge clk);
    check(idx, {ang_of(hall, 1'b0), 8'h00});
    $display("start angle test done");
    wait_sig(0, 600);
    // 0xFFFF first so the index is made to wrap
    for (i = 0; i < 5; i++)
    begin
      last = idx;
      step = (i == 0) ? 16'hFFFF : 16'($random(seed));
      h0 = hcnt;
      wait_sig(0, 600);
      check(16'(n), 16'h01F4);
      check(idx, 16'(last + step));
      check(act_since(h0), 16'h0007);
    end
    $display("update test done");
    // with zero magnitude all three duties must match
    // a midpoint duty stays high for half a period less the dead time
    mag = 8'h00;
    wait_sig(0, 600);
    h0 = hcnt;
    wait_sig(0, 600);
    check(16'(hcnt[1] - h0[1]), 16'(hcnt[0] - h0[0]));
    check(16'(hcnt[2] - h0[2]), 16'(hcnt[0] - h0[0]));
    check(16'(hcnt[0] - h0[0]), 16'(hssp_pkg::CNT_HALF - dt));
    $display("magnitude test done");
    step = 16'h0000;
    mag = 8'hC0;
    for (i = 0; i < 12; i++)
    begin
      rev = (i >= 6);
      // the step back to an earlier code at i = 6 makes one stamp certain
      cap = (i == 6) ? h4 : 3'($random(seed));
      req = 1'b1;
      @(negedge clk);
      req = 1'b0;
      wait_sig(1, 10);
      check(idx, {ang_of(hall, rev), 8'h00});
      check(16'(sv), 16'(cap == hall));
      if (sv)
        check(stamp, 16'(cyc - 1));
      if (i == 4)
        h4 = hall;
      if (i > 0)
        check(per, 16'(gap + n));
      k = 20 + ($random(seed) & 63);
      repeat (k) @(negedge clk);
      gap = k + 1;
    end
    $display("hall test done");
    // trip right after an update, so the clearing update is far away
    wait_sig(0, 600);
    fault = 1'b1;
    #1;
    check({10'h000, hi, lo}, 16'h0000);
    repeat (5) @(negedge clk);
    check(16'(trip), 16'h0001);
    fault = 1'b0;
    repeat (2) @(negedge clk);
    check({10'h000, hi, lo}, 16'h0000);
    wait_sig(0, 600);
    repeat (2) @(negedge clk);
    check(16'(trip), 16'h0000);
    $display("fault test done");
    en = 1'b0;
    wait_sig(0, 600);
    h0 = hcnt;
    wait_sig(0, 600);
    check(act_since(h0), 16'h0000);
    check(16'(shoot), 16'h0000);
    $display("enable test done");
    print_verdict();
  end

  // hang guard, well beyond the length of the sequence
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    print_verdict();
  end
endmodule // hssp_bench
`default_nettype wire
